// File: verilog/bfs_status_top.sv
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
// Function
// - Sense pin floating or grounded sets fault.
// - Fault blocks converter start while off.
// - Fault switches running converter off at once.
// - Fault stops clock on phase clock pin.
// - Fallback fault pulls compensation node low.
// - Converter disable prevents fault from setting.
// - Outside fallback, converter stays off until fault read-cleared.
// - Fallback auto-clears fault every restart period.
// - First limit hit sets per-phase internal flag.
// - Three clean cycles reset internal flag.
// - Flag held through filter latches overcurrent.
// - Ten unreached cycles set peak timeout.
// - Ten reached cycles clear peak timeout.
// - Bit zero gives the frame odd parity.
module bfs_status_top #(
  parameter int unsigned FILTER_CYCLES = bfs_pkg::OCP_FILTER_CYCLES,
  parameter int unsigned RESTART_CYCLES = bfs_pkg::AUTO_RESTART_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic output_sense_fault,
  input wire logic switching_clock,
  input wire logic phase_one_limit,
  input wire logic phase_two_limit,
  input wire logic phase_one_level,
  input wire logic phase_two_level,
  output logic converter_enable,
  output logic phase_clock_out,
  output logic phase_clock_oe,
  output logic comp_pull_low
);

  localparam int unsigned RW = $clog2(RESTART_CYCLES + 1);
  localparam logic [RW-1:0] RESTART_LAST = RW'(RESTART_CYCLES - 1);

  if (RESTART_CYCLES < 2) begin : g_bad_restart
    $error("Restart count must be at least two cycles.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic clk_prev_q;

  // Every pin input passes two flip-flops; only the second stage is read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
      clk_prev_q <= 1'b0;
    end else begin
      meta_q <= {phase_two_level, phase_one_level, phase_two_limit,
                 phase_one_limit, switching_clock, output_sense_fault};
      sync_q <= meta_q;
      clk_prev_q <= sync_q[1];
    end
  end

  wire sense_fault = sync_q[0];
  wire sw_clk = sync_q[1];
  wire [1:0] limit_now = sync_q[3:2];
  wire [1:0] level_now = sync_q[5:4];
  // A rising edge of the switching clock closes one switching cycle.
  wire cycle_end = sw_clk && !clk_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Per-cycle accumulation of comparator events.

  logic [1:0] hit_acc_q;
  logic [1:0] lvl_acc_q;
  wire [1:0] hit_cycle = hit_acc_q | limit_now;
  wire [1:0] lvl_cycle = lvl_acc_q | level_now;

  // A brief comparator pulse anywhere in the cycle counts for that cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_acc_q <= 2'h0;
      lvl_acc_q <= 2'h0;
    end else if (cycle_end) begin
      hit_acc_q <= 2'h0;
      lvl_acc_q <= 2'h0;
    end else begin
      hit_acc_q <= hit_cycle;
      lvl_acc_q <= lvl_cycle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  logic [2:0] ctrl_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic err_q;

  wire sel_status = (paddr == bfs_pkg::STATUS_OFFSET);
  wire sel_control = (paddr == bfs_pkg::CONTROL_OFFSET);
  wire sel_state = (paddr == bfs_pkg::STATE_OFFSET);
  wire addr_ok = sel_status || sel_control || sel_state;
  wire access = psel && penable;
  wire first_access = access && !ack_q;
  wire done = access && ack_q;
  wire wr_ctrl = done && pwrite && sel_control;
  // The status frame closes at the completing edge of the read.
  wire rd_clear = done && !pwrite && sel_status;

  wire conv_disable = ctrl_q[bfs_pkg::CTRL_DISABLE_BIT];
  wire fallback = ctrl_q[bfs_pkg::CTRL_FALLBACK_BIT];
  wire run_request = ctrl_q[bfs_pkg::CTRL_RUN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Output pin fault and auto-restart.

  logic fault_q;
  logic [RW-1:0] restart_q;
  wire fault_set = sense_fault && !conv_disable;
  wire restart_done = fallback && fault_q && (restart_q == RESTART_LAST);
  wire fault_clear = rd_clear || restart_done;

  // The set condition wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else if (fault_set) begin
      fault_q <= 1'b1;
    end else if (fault_clear) begin
      fault_q <= 1'b0;
    end
  end

  // Restart timer runs only in fallback while the fault stands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_q <= '0;
    end else if (!(fallback && fault_q) || restart_done) begin
      restart_q <= '0;
    end else begin
      restart_q <= restart_q + RW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter run control.

  bfs_pkg::bfs_conv_state_t conv_q;
  bfs_pkg::bfs_conv_state_t conv_d;
  wire may_run = run_request && !conv_disable && !fault_q;

  // Start needs a clear fault bit; a fault drops a running converter.
  always_comb begin
    conv_d = conv_q;
    case (conv_q)
      bfs_pkg::BFS_CONV_OFF: begin
        if (may_run) begin
          conv_d = bfs_pkg::BFS_CONV_RUN;
        end
      end
      bfs_pkg::BFS_CONV_RUN: begin
        if (!may_run) begin
          conv_d = bfs_pkg::BFS_CONV_OFF;
        end
      end
      default: conv_d = bfs_pkg::BFS_CONV_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_q <= bfs_pkg::BFS_CONV_OFF;
    end else begin
      conv_q <= conv_d;
    end
  end

  // The enable is gated by the live fault as well, so the switch-off does
  // not wait for the state register to follow.
  assign converter_enable = (conv_q == bfs_pkg::BFS_CONV_RUN) && !fault_q;

  ////////////////////////////////////////////////////////////////////////////
  // Phase clock pin and compensation pull-down.

  logic clk_out_q;
  logic clk_oe_q;
  logic comp_low_q;

  // Any fault parks the pin low, whether the converter ran or not.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out_q <= 1'b0;
      clk_oe_q <= 1'b0;
      comp_low_q <= 1'b0;
    end else begin
      clk_out_q <= sw_clk && !fault_q && !fault_set;
      clk_oe_q <= 1'b1;
      comp_low_q <= fallback && (fault_q || fault_set);
    end
  end

  assign phase_clock_out = clk_out_q;
  assign phase_clock_oe = clk_oe_q;
  assign comp_pull_low = comp_low_q;

  ////////////////////////////////////////////////////////////////////////////
  // Phase monitors.

  bfs_pkg::bfs_phase_status_t ph_one;
  bfs_pkg::bfs_phase_status_t ph_two;

  bfs_phase_monitor #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_phase_one (
    .pclk(pclk),
    .presetn(presetn),
    .cycle_end(cycle_end),
    .limit_hit(hit_cycle[0]),
    .level_reached(lvl_cycle[0]),
    .clear_ocp(rd_clear),
    .status(ph_one)
  );

  bfs_phase_monitor #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_phase_two (
    .pclk(pclk),
    .presetn(presetn),
    .cycle_end(cycle_end),
    .limit_hit(hit_cycle[1]),
    .level_reached(lvl_cycle[1]),
    .clear_ocp(rd_clear),
    .status(ph_two)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status frame and readback.

  logic [bfs_pkg::FRAME_WIDTH-1:0] frame_raw;
  logic [bfs_pkg::FRAME_WIDTH-1:0] frame;
  logic [31:0] rd_mux;

  // Upper status bits are outside this block and read as zero.
  always_comb begin
    frame_raw = '0;
    frame_raw[bfs_pkg::OUT_FAULT_BIT] = fault_q;
    frame_raw[bfs_pkg::PH2_OCP_BIT] = ph_two.ocp_status;
    frame_raw[bfs_pkg::PH1_OCP_BIT] = ph_one.ocp_status;
    frame_raw[bfs_pkg::PH2_PEAK_BIT] = ph_two.peak_timeout;
    frame_raw[bfs_pkg::PH1_PEAK_BIT] = ph_one.peak_timeout;
    frame = frame_raw;
    frame[bfs_pkg::PARITY_BIT] = ~^frame_raw[bfs_pkg::FRAME_WIDTH-1:1];
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_status) begin
      rd_mux = {8'h00, frame};
    end else if (sel_control) begin
      rd_mux = {29'h0000_0000, ctrl_q};
    end else if (sel_state) begin
      rd_mux[bfs_pkg::STATE_RUNNING_BIT] = converter_enable;
      rd_mux[bfs_pkg::STATE_PH1_FLAG_BIT] = ph_one.ocp_flag;
      rd_mux[bfs_pkg::STATE_PH2_FLAG_BIT] = ph_two.ocp_flag;
    end
  end

  // One wait state lets read data come straight from a flip-flop; the
  // captured frame is the value the host sees before any clear lands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (first_access) begin
      ack_q <= 1'b1;
      rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      err_q <= !addr_ok;
    end else begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end
  end

  // Control register; unmapped or read-only writes are dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= bfs_pkg::CONTROL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[2:0];
    end
  end

  assign pready = ack_q;
  assign pslverr = ack_q && err_q;
  assign prdata = rdata_q;

endmodule

// File: verilog/bfs_pkg.sv
package bfs_pkg;

  // Clock and timing figures; filter and restart cycle counts are derived from the times.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned OCP_FILTER_TIME_NS = 2000000;
  localparam int unsigned OCP_FILTER_CYCLES = OCP_FILTER_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned AUTO_RESTART_TIME_NS = 10000000;
  localparam int unsigned AUTO_RESTART_CYCLES = AUTO_RESTART_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned OCP_MISS_CYCLES = 3;
  localparam int unsigned PEAK_RUN_CYCLES = 10;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [7:0] CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] STATE_OFFSET = 8'h08;

  // Status frame layout and width.
  localparam int unsigned FRAME_WIDTH = 24;
  localparam int unsigned PARITY_BIT = 0;
  localparam int unsigned PH1_PEAK_BIT = 1;
  localparam int unsigned PH2_PEAK_BIT = 2;
  localparam int unsigned PH1_OCP_BIT = 3;
  localparam int unsigned PH2_OCP_BIT = 4;
  localparam int unsigned OUT_FAULT_BIT = 6;

  // Control register fields and reset value.
  localparam int unsigned CTRL_DISABLE_BIT = 0;
  localparam int unsigned CTRL_FALLBACK_BIT = 1;
  localparam int unsigned CTRL_RUN_BIT = 2;
  localparam logic [2:0] CONTROL_RESET = 3'h0;

  // State register fields.
  localparam int unsigned STATE_RUNNING_BIT = 0;
  localparam int unsigned STATE_PH1_FLAG_BIT = 1;
  localparam int unsigned STATE_PH2_FLAG_BIT = 2;

  // Converter run state, one-hot.
  typedef enum logic [1:0] {
    BFS_CONV_OFF = 2'b01,
    BFS_CONV_RUN = 2'b10
  } bfs_conv_state_t;

  // Per-phase diagnostic results.
  typedef struct packed {
    logic ocp_flag;
    logic ocp_status;
    logic peak_timeout;
  } bfs_phase_status_t;

endpackage

// File: verilog/bfs_phase_monitor.sv
`timescale 1ns/1ps
module bfs_phase_monitor #(
  parameter int unsigned FILTER_CYCLES = bfs_pkg::OCP_FILTER_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cycle_end,
  input wire logic limit_hit,
  input wire logic level_reached,
  input wire logic clear_ocp,
  output bfs_pkg::bfs_phase_status_t status
);

  localparam int unsigned FW = $clog2(FILTER_CYCLES + 1);
  localparam logic [FW-1:0] FILTER_LAST = FW'(FILTER_CYCLES - 1);
  localparam logic [1:0] MISS_LAST = 2'(bfs_pkg::OCP_MISS_CYCLES - 1);
  localparam logic [3:0] PEAK_LAST = 4'(bfs_pkg::PEAK_RUN_CYCLES - 1);

  if (FILTER_CYCLES < 2) begin : g_bad_filter
    $error("Filter count must be at least two cycles.");
  end

  logic flag_q;
  logic [1:0] miss_q;
  logic [FW-1:0] filt_q;
  logic latch_q;
  logic [3:0] low_q;
  logic [3:0] high_q;
  logic timeout_q;
  wire filter_done = flag_q && (filt_q == FILTER_LAST);
  wire miss_end = cycle_end && !limit_hit && (miss_q == MISS_LAST);

  // Internal flag: set on first hit, dropped after three clean cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
      miss_q <= 2'h0;
    end else if (cycle_end) begin
      if (limit_hit) begin
        flag_q <= 1'b1;
        miss_q <= 2'h0;
      end else if (flag_q) begin
        miss_q <= miss_end ? 2'h0 : miss_q + 2'h1;
        if (miss_end) begin
          flag_q <= 1'b0;
        end
      end
    end
  end

  // Filter window runs while the flag holds; restarting it when the flag
  // drops means only an unbroken overcurrent episode can latch the status.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q <= '0;
    end else if (!flag_q || filter_done) begin
      filt_q <= '0;
    end else begin
      filt_q <= filt_q + FW'(1);
    end
  end

  // Latched status: a new set in the clearing cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 1'b0;
    end else if (filter_done) begin
      latch_q <= 1'b1;
    end else if (clear_ocp) begin
      latch_q <= 1'b0;
    end
  end

  // Peak comparator timeout with ten-cycle runs in both directions.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= 4'h0;
      high_q <= 4'h0;
      timeout_q <= 1'b0;
    end else if (cycle_end) begin
      if (level_reached) begin
        low_q <= 4'h0;
        high_q <= (high_q == PEAK_LAST) ? high_q : high_q + 4'h1;
        if (high_q == PEAK_LAST) begin
          timeout_q <= 1'b0;
        end
      end else begin
        high_q <= 4'h0;
        low_q <= (low_q == PEAK_LAST) ? low_q : low_q + 4'h1;
        if (low_q == PEAK_LAST) begin
          timeout_q <= 1'b1;
        end
      end
    end
  end

  assign status.ocp_flag = flag_q;
  assign status.ocp_status = latch_q;
  assign status.peak_timeout = timeout_q;

endmodule

// File: tb/bfs_pin_model.sv
`timescale 1ns/1ps
module bfs_pin_model (
  input wire logic [1:0] lim_req,
  input wire logic [1:0] lvl_req,
  output logic switching_clock,
  output logic [1:0] limit,
  output logic [1:0] level
);
  // The power stage switches all the time, so this clock never stands still.
  initial begin
    switching_clock = 1'b0;
    limit = 2'b00;
    level = 2'b11;
    forever #62.5 switching_clock = ~switching_clock;
  end
  // Comparators change mid-cycle and hold for a whole switching cycle.
  always @(negedge switching_clock) begin
    limit <= lim_req;
    level <= lvl_req;
  end
endmodule

// File: tb/bfs_status_asserts.sv
`timescale 1ns/1ps
module bfs_status_asserts #(
  parameter int unsigned FILTER_CYCLES = 2,
  parameter int unsigned RESTART_CYCLES = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic output_sense_fault,
  input wire logic converter_enable,
  input wire logic phase_clock_out,
  input wire logic phase_clock_oe,
  input wire logic comp_pull_low
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  // A transfer opens with a setup cycle and its first access cycle.
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable;
  endsequence
  a_ready_one_wait: assert property (apb_setup ##1 apb_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response carries data");
  a_frame_odd_parity: assert property (
    pready && !pwrite && paddr == bfs_pkg::STATUS_OFFSET |->
    (^prdata[23:0]) && prdata[31:24] == 8'h00)
    else $error("status frame parity even");
  a_sense_stops_run: assert property (
    output_sense_fault [*3] |=> !converter_enable)
    else $error("converter runs with sense fault");
  a_start_needs_clean: assert property (
    $rose(converter_enable) |-> !$past(output_sense_fault, 3))
    else $error("converter started during fault");
  a_pull_quiets_pins: assert property (
    comp_pull_low |-> !converter_enable && !phase_clock_out)
    else $error("clock or run active during pull low");
  a_clock_pin_driven: assert property ($past(presetn) |-> phase_clock_oe)
    else $error("phase clock pin released");
endmodule
bind bfs_status_top bfs_status_asserts #(.FILTER_CYCLES(FILTER_CYCLES),
  .RESTART_CYCLES(RESTART_CYCLES)) u_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .output_sense_fault(output_sense_fault),
  .converter_enable(converter_enable), .phase_clock_out(phase_clock_out),
  .phase_clock_oe(phase_clock_oe), .comp_pull_low(comp_pull_low));

// File: tb/boost_fault_status_bits_bench.sv
`timescale 1ns/1ps
module boost_fault_status_bits_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, output_sense_fault = 1'b0, sw_clk, run, pclk_out, pclk_oe, pull;
  logic [1:0] lim_req = 2'b00, lvl_req = 2'b11, lim, lvl;
  int err_count = 0, check_count = 0, cyc_count = 0;
  bfs_pin_model u_pins (.lim_req(lim_req), .lvl_req(lvl_req), .switching_clock(sw_clk),
    .limit(lim), .level(lvl));
  // Short counts keep the filter and restart waits cheap to simulate.
  // The filter must outlast a lone hit (about 63 cycles) and stay below a long episode.
  bfs_status_top #(.FILTER_CYCLES(100), .RESTART_CYCLES(50)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .output_sense_fault(output_sense_fault), .switching_clock(sw_clk),
    .phase_one_limit(lim[0]), .phase_two_limit(lim[1]), .phase_one_level(lvl[0]),
    .phase_two_level(lvl[1]), .converter_enable(run), .phase_clock_out(pclk_out),
    .phase_clock_oe(pclk_oe), .comp_pull_low(pull));
  ////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling that turns a hang into a failure.
  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc_count++;
    if (cyc_count == 10000) begin
      err_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Request held until pready is seen at an edge; data taken at that edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
      output logic [31:0] d, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    // A transfer that never completes counts as a mismatch.
    if (pready !== 1'b1) begin
      err_count++;
      $display("Error pready expected 1 seen %b", pready);
    end
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic er;
    apb(1'b0, a, 32'h0, d, er);
    chk(nm, e, d);
    chk("pslverr", {31'h0, a == 8'h0c}, {31'h0, er});
  endtask
  // Expected frame: bits above zero plus the bit that makes the ones odd.
  task automatic rs(input logic [23:0] b);
    rd("status", bfs_pkg::STATUS_OFFSET, {8'h00, b[23:1], ~^b[23:1]});
  endtask
  task automatic wc(input logic [31:0] v);
    logic [31:0] d;
    logic er;
    apb(1'b1, bfs_pkg::CONTROL_OFFSET, v, d, er);
  endtask
  task automatic fault(input int n);
    output_sense_fault <= 1'b1;
    cyc(n);
    output_sense_fault <= 1'b0;
    cyc(6);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic hi;
    cyc(12);
    presetn <= 1'b1;
    rs(24'h0);
    rd("control", bfs_pkg::CONTROL_OFFSET, 32'h0);
    rd("state", bfs_pkg::STATE_OFFSET, 32'h0);
    rd("unmapped", 8'h0c, 32'h0);
    wc(32'h4);
    cyc(6);
    chk("run", 32'h1, {31'h0, run});
    // Fault while running: converter off and no clock until cleared by a read.
    output_sense_fault <= 1'b1;
    cyc(8);
    chk("run", 32'h0, {31'h0, run});
    hi = 1'b0;
    repeat (30) begin
      @(posedge pclk);
      hi = hi | pclk_out;
    end
    chk("phase clock", 32'h0, {31'h0, hi});
    fault(1);
    chk("run", 32'h0, {31'h0, run});
    rs(24'h40);
    rs(24'h0);
    cyc(6);
    chk("run", 32'h1, {31'h0, run});
    // With the fault gone the pin carries the switching clock again.
    hi = 1'b0;
    repeat (30) begin
      @(posedge pclk);
      hi = hi | pclk_out;
    end
    chk("phase clock", 32'h1, {31'h0, hi});
    chk("phase clock oe", 32'h1, {31'h0, pclk_oe});
    // Fault while off blocks the start.
    wc(32'h0);
    fault(4);
    wc(32'h4);
    cyc(6);
    chk("run", 32'h0, {31'h0, run});
    rs(24'h40);
    wc(32'h5);
    fault(8);
    rs(24'h0);
    // Fallback: compensation pulled low, then the restart timer clears the bit.
    wc(32'h6);
    output_sense_fault <= 1'b1;
    cyc(8);
    chk("pull low", 32'h1, {31'h0, pull});
    fault(1);
    cyc(60);
    chk("pull low", 32'h0, {31'h0, pull});
    chk("run", 32'h1, {31'h0, run});
    rs(24'h0);
    wc(32'h4);
    // Overcurrent: a lone hit drops before the filter; a long one latches.
    for (int i = 0; i < 2; i++) begin
      lim_req[i] <= 1'b1;
      cyc(13);
      lim_req[i] <= 1'b0;
      cyc(18);
      rd("state", bfs_pkg::STATE_OFFSET, 32'h1 | (32'h2 << i));
      cyc(60);
      rd("state", bfs_pkg::STATE_OFFSET, 32'h1);
      rs(24'h0);
      lim_req[i] <= 1'b1;
      cyc(120);
      lim_req[i] <= 1'b0;
      cyc(70);
      rs(24'h8 << i);
      rs(24'h0);
      lvl_req[i] <= 1'b0;
      cyc(170);
      rs(24'h2 << i);
      lvl_req[i] <= 1'b1;
      cyc(90);
      rs(24'h2 << i);
      cyc(80);
      rs(24'h0);
    end
    tally_and_finish();
  end
endmodule
